// [design/dlip_pkg.sv]
// package: constants and types for the load/idle/port instruction group
package dlip_pkg;

  // ----------------------------------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR   = 8'h00; // write: opcode word to execute
  localparam logic [7:0] ADDR_OPERAND = 8'h04; // write: second word / data read
  localparam logic [7:0] ADDR_CTRL    = 8'h08; // variant, sxm, interrupt_mask_flag, multiplicand
  localparam logic [7:0] ADDR_STATUS  = 8'h0c; // idle, powerdown, busy
  localparam logic [7:0] ADDR_ACC     = 8'h10; // accumulator
  localparam logic [7:0] ADDR_PC      = 8'h14; // program counter
  localparam logic [7:0] ADDR_TIMER   = 8'h18; // free running timer
  localparam logic [7:0] ADDR_WAKE    = 8'h1c; // write: bit0 masked irq, bit1 nmi
  localparam logic [7:0] ADDR_AUX0    = 8'h20; // aux registers 0..7 at 0x20..0x3c

  // ctrl field positions
  localparam int CTRL_VARIANT = 0;  // 1 = later variant
  localparam int CTRL_SXM     = 1;
  localparam int CTRL_INTERRUPT_MASK_FLAG    = 2;
  localparam int CTRL_MPY_LSB = 16; // multiplicand in bits 31:16

  // reset values
  localparam logic        RST_INTERRUPT_MASK_FLAG    = 1'b1;
  localparam logic        RST_SXM     = 1'b1;
  localparam logic        RST_VARIANT = 1'b1;
  localparam logic [15:0] RST_PC      = 16'h0000;

  // opcode patterns
  localparam logic [15:0] OPC_IDLE     = 16'hce1f;
  localparam logic [3:0]  OPC_IN_HI    = 4'h8;    // 1000 pppp
  localparam logic [3:0]  OPC_LAC_HI   = 4'h2;    // 0010 ssss
  localparam logic [7:0]  OPC_LOAD_ACC_SHORT_CONST_OP_HI  = 8'hca;
  localparam logic [7:0]  OPC_LOAD_ACC_VAR_SHIFT_OP_HI  = 8'h42;
  localparam logic [4:0]  OPC_LOAD_ACC_LONG_CONST_OP_HI  = 5'h1a;   // 1101 ssss 00000001, only bits 4:1 compared
  localparam logic [7:0]  OPC_LOAD_ACC_LONG_CONST_OP_LO  = 8'h01;
  localparam logic [4:0]  OPC_LAR_HI   = 5'h06;   // 00110 aaa

  // apb error value
  localparam logic [31:0] BAD_ADDR_DATA = 32'h0000_0000;

  // external bus request carrier
  typedef struct packed {
    logic [15:0] addr;
    logic        io_space_strobe_n;
    logic        external_strobe_n;
    logic        read_n_write;
  } dlip_ext_bus_t;

endpackage

// [design/dlip_core.sv]
// design: decoder and executor for idle, port-read and load instructions
//------------------------------------------------------------------
// Behaviour
// - idle stops fetching until reset or interrupt
// - idle advances program counter once only
// - later variant idle clears interrupt mask
// - earlier variant idle keeps interrupt mask
// - later variant idle enters power-down
// - timer keeps counting while idle
// - port read moves port word into memory
// - port number on low address, upper zero
// - port read drives io strobe low
// - variable shift from multiplicand low nibble
// - variable shift covers zero through fifteen
// - shifted memory load extends per mode flag
// - short constant loads unsigned into low bits
// - short constant zeroes upper 24 bits
// - long constant zero-filled when mode clear
// - accumulator msb set only negative extended
// - long constant default shift is zero
// - aux load copies memory word to register
// - mask flag set ignores maskable interrupts
//------------------------------------------------------------------
`timescale 1ns/1ps
module dlip_core (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // external bus to io ports and data memory
  output logic      [15:0] ext_addr,
  output logic             io_space_strobe_n,
  output logic             external_strobe_n,
  output logic             ext_read_n_write,
  output logic      [15:0] ext_wdata,
  input  wire logic [15:0] ext_rdata,
  input  wire logic        ext_ready,
  // interrupt requests from outside
  input  wire logic        irq_maskable,
  input  wire logic        irq_nonmaskable,
  // status
  output logic             idle_state,
  output logic             power_down
);

  // execution states
  // ready:    waits for an opcode write from software
  // rd_addr:  spare read setup step, not entered by the decoder
  // rd_wait:  read strobe low, waits for the bus ready
  // wr:       one quiet cycle, then the memory write of a port word
  // wr_wait:  write strobe low, waits for the bus ready
  // idle:     no fetch, program counter frozen, timer still runs
  // hazard: a new opcode is only taken in ready, writes while busy are lost except wake register pulses
  typedef enum logic [2:0] {
    ST_READY, ST_RD_ADDR, ST_RD_WAIT, ST_WR, ST_WR_WAIT, ST_IDLE
  } dlip_state_t;

  //------------------------------------------------------------------
  // state
  //------------------------------------------------------------------
  dlip_state_t   state_ff;
  logic [15:0]   pc_ff;
  logic [31:0]   acc_ff;
  logic [15:0]   aux_ff [8];
  logic [15:0]   mpy_ff;
  logic          sxm_ff;
  logic          interrupt_mask_flag_ff;
  logic          variant_ff;
  logic [31:0]   timer_ff;
  logic [15:0]   instr_ff;
  logic [15:0]   operand_ff;
  logic [15:0]   rdata_ff;
  logic          go_ff;
  dlip_pkg::dlip_ext_bus_t bus_ff;
  logic [15:0]   wdata_ff;
  logic          irqm_s1_ff, irqm_s2_ff;
  logic          nmi_s1_ff, nmi_s2_ff;
  logic          sw_irqm_ff, sw_nmi_ff;

  // apb qualifiers and combined wake request
  // wr_acc marks the access edge of a write, the only edge that changes state
  // rd_acc opens the read mux during setup and access of a read
  // wake merges the synchronised pins and the software pulses
  logic          wr_acc;
  logic          rd_acc;
  logic          wake;

  //------------------------------------------------------------------
  // helpers
  //------------------------------------------------------------------
  // shift a 16-bit word left, extending per mode
  function automatic logic [31:0] shift_load(input logic [15:0] v, input logic [3:0] sh,
                                             input logic ext);
    logic [31:0] w;
    w = ext ? {{16{v[15]}}, v} : {16'h0000, v};
    shift_load = w << sh;
  endfunction

  // apb address decode for an aux register
  function automatic logic is_aux(input logic [7:0] a);
    is_aux = (a[7:5] == dlip_pkg::ADDR_AUX0[7:5]) && (a[1:0] == 2'b00);
  endfunction

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & ~pwrite;

  //------------------------------------------------------------------
  // apb slave, zero wait states
  //------------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // read mux, registered data comes straight from flops
  always_comb begin
    prdata = dlip_pkg::BAD_ADDR_DATA;
    if (rd_acc) begin
      case (paddr)
        dlip_pkg::ADDR_INSTR:   prdata = {16'h0000, instr_ff};
        dlip_pkg::ADDR_OPERAND: prdata = {16'h0000, rdata_ff};
        dlip_pkg::ADDR_CTRL:    prdata = {mpy_ff, 13'h0000, interrupt_mask_flag_ff, sxm_ff, variant_ff};
        dlip_pkg::ADDR_STATUS:  prdata = {29'h0000_0000, go_ff | (state_ff != ST_READY),
                                          power_down, idle_state};
        dlip_pkg::ADDR_ACC:     prdata = acc_ff;
        dlip_pkg::ADDR_PC:      prdata = {16'h0000, pc_ff};
        dlip_pkg::ADDR_TIMER:   prdata = timer_ff;
        default: begin
          if (is_aux(paddr)) begin
            prdata = {16'h0000, aux_ff[paddr[4:2]]};
          end
        end
      endcase
    end
  end

  //------------------------------------------------------------------
  // interrupt inputs: pins synchronised, software pokes direct
  //------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqm_s1_ff <= 1'b0;
      irqm_s2_ff <= 1'b0;
      nmi_s1_ff  <= 1'b0;
      nmi_s2_ff  <= 1'b0;
    end else begin
      irqm_s1_ff <= irq_maskable;
      irqm_s2_ff <= irqm_s1_ff;
      nmi_s1_ff  <= irq_nonmaskable;
      nmi_s2_ff  <= nmi_s1_ff;
    end
  end

  // one-cycle software wake pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_irqm_ff <= 1'b0;
      sw_nmi_ff  <= 1'b0;
    end else begin
      sw_irqm_ff <= wr_acc && (paddr == dlip_pkg::ADDR_WAKE) && pwdata[0];
      sw_nmi_ff  <= wr_acc && (paddr == dlip_pkg::ADDR_WAKE) && pwdata[1];
    end
  end

  // maskable request counts only while mask flag is clear
  assign wake = ((irqm_s2_ff | sw_irqm_ff) & ~interrupt_mask_flag_ff) | nmi_s2_ff | sw_nmi_ff;

  //------------------------------------------------------------------
  // timer runs in every state
  //------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_ff <= 32'h0000_0000;
    end else begin
      timer_ff <= timer_ff + 32'h0000_0001;
    end
  end

  //------------------------------------------------------------------
  // software configuration and instruction issue
  //------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ff   <= 16'h0000;
      operand_ff <= 16'h0000;
      mpy_ff     <= 16'h0000;
      sxm_ff     <= dlip_pkg::RST_SXM;
      variant_ff <= dlip_pkg::RST_VARIANT;
      go_ff      <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      if (wr_acc && state_ff == ST_READY && !go_ff) begin
        case (paddr)
          dlip_pkg::ADDR_INSTR: begin
            instr_ff <= pwdata[15:0];
            go_ff    <= 1'b1;
          end
          dlip_pkg::ADDR_OPERAND: operand_ff <= pwdata[15:0];
          dlip_pkg::ADDR_CTRL: begin
            variant_ff <= pwdata[dlip_pkg::CTRL_VARIANT];
            sxm_ff     <= pwdata[dlip_pkg::CTRL_SXM];
            mpy_ff     <= pwdata[dlip_pkg::CTRL_MPY_LSB +: 16];
          end
          default: ;
        endcase
      end
    end
  end

  //------------------------------------------------------------------
  // decode and execute
  //------------------------------------------------------------------
  logic is_idle, is_in, is_lac, is_load_acc_short_const_op, is_load_acc_var_shift_op, is_load_acc_long_const_op, is_lar;
  assign is_idle = instr_ff == dlip_pkg::OPC_IDLE;
  assign is_in   = instr_ff[15:12] == dlip_pkg::OPC_IN_HI;
  assign is_lac  = instr_ff[15:12] == dlip_pkg::OPC_LAC_HI;
  assign is_load_acc_short_const_op = instr_ff[15:8] == dlip_pkg::OPC_LOAD_ACC_SHORT_CONST_OP_HI;
  assign is_load_acc_var_shift_op = instr_ff[15:8] == dlip_pkg::OPC_LOAD_ACC_VAR_SHIFT_OP_HI;
  // long constant: top nibble fixed, shift in bits 11:8, fixed low byte
  assign is_load_acc_long_const_op = (instr_ff[15:12] == dlip_pkg::OPC_LOAD_ACC_LONG_CONST_OP_HI[4:1]) &&
                   (instr_ff[7:0] == dlip_pkg::OPC_LOAD_ACC_LONG_CONST_OP_LO);
  assign is_lar  = instr_ff[15:11] == dlip_pkg::OPC_LAR_HI;

  // decode notes
  // the decoder looks only at the held opcode, never at the bus
  // opcodes outside this group just advance the program counter
  // short and long constants finish in the issue cycle
  // memory loads and the port read leave through the external bus
  // only direct addressing on page zero is carried out here
  // data memory address from the low seven bits
  logic [15:0] dma;
  assign dma = {9'h000, instr_ff[6:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_READY;
      pc_ff    <= dlip_pkg::RST_PC;
      acc_ff   <= 32'h0000_0000;
      interrupt_mask_flag_ff  <= dlip_pkg::RST_INTERRUPT_MASK_FLAG;
      rdata_ff <= 16'h0000;
      wdata_ff <= 16'h0000;
      bus_ff   <= '{addr: 16'h0000, io_space_strobe_n: 1'b1,
                    external_strobe_n: 1'b1, read_n_write: 1'b1};
      for (int i = 0; i < 8; i++) begin
        aux_ff[i] <= 16'h0000;
      end
    end else begin
      case (state_ff)
        ST_READY: begin
          if (wr_acc && paddr == dlip_pkg::ADDR_CTRL && !go_ff) begin
            interrupt_mask_flag_ff <= pwdata[dlip_pkg::CTRL_INTERRUPT_MASK_FLAG];
          end
          if (go_ff) begin
            if (is_load_acc_long_const_op) begin
              pc_ff <= pc_ff + 16'h0002;
              // constant from second word, shift field defaults to zero
              acc_ff <= shift_load(operand_ff, instr_ff[11:8], sxm_ff);
            end else begin
              pc_ff <= pc_ff + 16'h0001;
            end
            if (is_idle) begin
              if (variant_ff) begin
                interrupt_mask_flag_ff <= 1'b0;
              end
              // earlier variant leaves mask untouched
              state_ff <= ST_IDLE;
            end else if (is_load_acc_short_const_op) begin
              acc_ff <= {24'h000000, instr_ff[7:0]};
            end else if (is_in) begin
              // port number low, upper address lines zero
              bus_ff <= '{addr: {12'h000, instr_ff[11:8]}, io_space_strobe_n: 1'b0,
                          external_strobe_n: 1'b0, read_n_write: 1'b1};
              state_ff <= ST_RD_WAIT;
            end else if (is_lac || is_load_acc_var_shift_op || is_lar) begin
              bus_ff <= '{addr: dma, io_space_strobe_n: 1'b1,
                          external_strobe_n: 1'b0, read_n_write: 1'b1};
              state_ff <= ST_RD_WAIT;
            end
          end
        end
        ST_RD_WAIT: begin
          if (ext_ready) begin
            rdata_ff <= ext_rdata;
            bus_ff   <= '{addr: 16'h0000, io_space_strobe_n: 1'b1,
                          external_strobe_n: 1'b1, read_n_write: 1'b1};
            if (is_in) begin
              wdata_ff <= ext_rdata;
              state_ff <= ST_WR;
            end else begin
              if (is_lac) begin
                acc_ff <= shift_load(ext_rdata, instr_ff[11:8], sxm_ff);
              end else if (is_load_acc_var_shift_op) begin
                acc_ff <= shift_load(ext_rdata, mpy_ff[3:0], sxm_ff);
              end else begin
                aux_ff[instr_ff[10:8]] <= ext_rdata;
              end
              state_ff <= ST_READY;
            end
          end
        end
        ST_WR: begin
          // write the port word into data memory
          bus_ff <= '{addr: dma, io_space_strobe_n: 1'b1,
                      external_strobe_n: 1'b0, read_n_write: 1'b0};
          state_ff <= ST_WR_WAIT;
        end
        ST_WR_WAIT: begin
          if (ext_ready) begin
            bus_ff <= '{addr: 16'h0000, io_space_strobe_n: 1'b1,
                        external_strobe_n: 1'b1, read_n_write: 1'b1};
            state_ff <= ST_READY;
          end
        end
        ST_IDLE: begin
          // no fetch, pc frozen until wake
          if (wake) begin
            state_ff <= ST_READY;
          end
        end
        default: state_ff <= ST_READY;
      endcase
    end
  end

  //------------------------------------------------------------------
  // outputs
  //------------------------------------------------------------------
  // bus pins come straight from the request flops
  // strobes therefore never glitch between two bus steps
  // address and direction change only together with the strobes
  // write data holds the last port word until the next port read
  // idle and power-down are decoded from the state register
  // power-down follows the variant bit as it stood at idle entry
  // a variant change while idle is refused by the issue logic
  // nothing here depends on the apb inputs, so no path runs through
  // from the register bus to the external pins within one cycle
  // the timer is not affected by any state, see its own process
  // a maskable wake with the mask set leaves the core idle, by design
  // the nonmaskable pin and pulse always end the idle state
  // after wake the next opcode write may follow at once
  // port read and memory write never overlap on the bus
  // the quiet cycle between them lets the strobes return high
  // ready is sampled once per step, a held ready is not reused
  // reset puts every strobe high and the address to zero
  assign ext_addr          = bus_ff.addr;
  assign io_space_strobe_n = bus_ff.io_space_strobe_n;
  assign external_strobe_n = bus_ff.external_strobe_n;
  assign ext_read_n_write  = bus_ff.read_n_write;
  assign ext_wdata         = wdata_ff;
  assign idle_state        = state_ff == ST_IDLE;
  assign power_down        = (state_ff == ST_IDLE) & variant_ff;

endmodule

// [tb/dlip_core_assertions.sv]
// checker: external bus and idle properties of the instruction core
`timescale 1ns/1ps
module dlip_chk (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  // external bus
  input wire logic [15:0] ext_addr,
  input wire logic        io_space_strobe_n,
  input wire logic        external_strobe_n,
  input wire logic        ext_read_n_write,
  input wire logic        ext_ready,
  // wake and status
  input wire logic        irq_maskable,
  input wire logic        irq_nonmaskable,
  input wire logic        idle_state,
  input wire logic        power_down
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // bus steps and wake conditions
  // ----------------------------------------------------------------
  sequence io_done_s;
    !io_space_strobe_n && ext_ready;
  endsequence
  sequence store_s;
    external_strobe_n ##1 (!external_strobe_n && !ext_read_n_write && io_space_strobe_n);
  endsequence
  sequence quiet_s;
    (!irq_maskable && !irq_nonmaskable && !(psel && pwrite))[*6];
  endsequence
  port_addr_a: assert property (!io_space_strobe_n |-> ext_addr[15:4] == 12'h000)
    else $error("port address upper bits not zero");
  io_read_a: assert property (
    !io_space_strobe_n |-> !external_strobe_n && ext_read_n_write)
    else $error("io strobe without a read strobe");
  strobe_hold_a: assert property (
    !external_strobe_n && !ext_ready |=> !external_strobe_n && $stable(ext_addr))
    else $error("bus request dropped before ready");
  strobe_end_a: assert property (!external_strobe_n && ext_ready |=> external_strobe_n)
    else $error("strobe not ended after ready");
  port_store_a: assert property (io_done_s |=> store_s)
    else $error("port word not written to memory");
  idle_stay_a: assert property (quiet_s ##0 idle_state |=> idle_state)
    else $error("idle left without a wake source");
  idle_quiet_a: assert property (idle_state |-> external_strobe_n)
    else $error("bus access while idle");
  pdown_idle_a: assert property (power_down |-> idle_state)
    else $error("power down outside idle");
  nmi_wake_a: assert property ((idle_state && irq_nonmaskable)[*2] |-> ##[0:6] !idle_state)
    else $error("nonmaskable request did not end idle");
  status_view_a: assert property (
    psel && penable && !pwrite && paddr == dlip_pkg::ADDR_STATUS
    |-> prdata[1:0] == {power_down, idle_state})
    else $error("status bits disagree with idle pins");
endmodule
bind dlip_core dlip_chk i_dlip_chk (.*);

// [tb/dlip_ext_model.sv]
// partner: external io ports and data memory on the core's bus
`timescale 1ns/1ps
module dlip_ext_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // bus from the core
  input  wire logic [15:0] ext_addr,
  input  wire logic        io_space_strobe_n,
  input  wire logic        external_strobe_n,
  input  wire logic        ext_read_n_write,
  input  wire logic [15:0] ext_wdata,
  output logic      [15:0] ext_rdata,
  output logic             ext_ready,
  // answer delay chosen by the bench
  input  wire logic [3:0]  wait_cycles
);
  logic [15:0] mem [0:127];
  logic [15:0] last_ff;
  logic [3:0]  cnt_ff;
  logic        rd_on;
  // data lines only valid in a read, else a flipped copy of the last word
  assign rd_on = !external_strobe_n && ext_read_n_write;
  assign ext_rdata = !rd_on ? ~last_ff :
                     !io_space_strobe_n ? {4'ha, ext_addr[3:0], 4'h5, ~ext_addr[3:0]} :
                     mem[ext_addr[6:0]];
  // one-cycle ready after the set waits; writes land on the ready edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 128; i++)
        mem[i] <= 16'h8000 ^ (16'(i) * 16'h0123);
      cnt_ff    <= 4'h0;
      ext_ready <= 1'b0;
      last_ff   <= 16'h0000;
    end else begin
      ext_ready <= !external_strobe_n && !ext_ready && cnt_ff >= wait_cycles;
      cnt_ff    <= (!external_strobe_n && !ext_ready) ? cnt_ff + 4'h1 : 4'h0;
      if (!external_strobe_n && ext_ready && !ext_read_n_write)
        mem[ext_addr[6:0]] <= ext_wdata;
      if (rd_on)
        last_ff <= ext_rdata;
    end
  end
endmodule

// [tb/tb.sv]
// bench: runs each instruction kind through apb and checks the results
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, t0;
  logic        pready, pslverr, io_space_strobe_n, external_strobe_n, ext_read_n_write;
  logic [15:0] ext_addr, ext_wdata, ext_rdata, pc, port_seen;
  logic        ext_ready, idle_state, power_down, w;
  logic        irq_maskable = 1'b0, irq_nonmaskable = 1'b0;
  logic [3:0]  wait_cycles = 4'h0;
  int          fails = 0, cmp_count = 0;
  always #20 pclk = ~pclk;
  dlip_core i_dlip_core (.*);
  dlip_ext_model i_dlip_ext_model (.*);
  // last address seen during a port read
  always @(posedge pclk)
    if (io_space_strobe_n === 1'b0) port_seen <= ext_addr;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] ld(input logic [15:0] v, input logic sx, input int sh);
    ld = (sx ? {{16{v[15]}}, v} : {16'h0, v}) << sh;
  endfunction
  function automatic logic [15:0] port_word(input logic [3:0] p);
    port_word = {4'ha, p, 4'h5, ~p};
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic give_up();
    fails++;
    complete_run();
  endtask
  // one apb transfer, read data taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) give_up();
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // issue an opcode, poll until done or idle, then check the counter
  task automatic exec(input logic [15:0] op, input int words);
    int n;
    apb(1'b1, dlip_pkg::ADDR_INSTR, {16'h0, op});
    for (n = 0; n < 32; n++) begin
      apb(1'b0, dlip_pkg::ADDR_STATUS, 32'h0);
      if (q[2] === 1'b0 || q[0] === 1'b1) break;
    end
    if (n == 32) give_up();
    pc = pc + 16'(words);
    apb(1'b0, dlip_pkg::ADDR_PC, 32'h0);
    `CHK("pc", {16'h0, pc}, q)
  endtask
  task automatic wait_wake();
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge pclk);
      w = idle_state;
      if (w === 1'b0) break;
    end
    if (n == 40) give_up();
    @(posedge pclk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    pc = dlip_pkg::RST_PC;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    exec({dlip_pkg::OPC_LOAD_ACC_SHORT_CONST_OP_HI, 8'hff}, 1);
    apb(1'b0, dlip_pkg::ADDR_ACC, 32'h0);
    `CHK("load_acc_short_const_op", 32'h0000_00ff, q)
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, dlip_pkg::ADDR_CTRL, {29'h0, 1'b1, s[1], 1'b1});
      apb(1'b1, dlip_pkg::ADDR_OPERAND, 32'h0000_8001);
      exec({4'hd, (s[0] ? 4'h4 : 4'h0), 8'h01}, 2);
      apb(1'b0, dlip_pkg::ADDR_ACC, 32'h0);
      `CHK("load_acc_long_const_op", ld(16'h8001, s[1], s[0] ? 4 : 0), q)
    end
    wait_cycles <= 4'h3;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, dlip_pkg::ADDR_CTRL, {29'h0, 1'b1, s[1], 1'b1});
      exec({4'h2, (s[0] ? 4'hf : 4'h0), 8'(10 + s)}, 1);
      apb(1'b0, dlip_pkg::ADDR_ACC, 32'h0);
      `CHK("lac", ld(i_dlip_ext_model.mem[10 + s], s[1], s[0] ? 15 : 0), q)
    end
    for (int t = 0; t < 16; t++) begin
      apb(1'b1, dlip_pkg::ADDR_CTRL, {12'hab0, 4'(t), 16'h0007});
      exec({dlip_pkg::OPC_LOAD_ACC_VAR_SHIFT_OP_HI, 8'(40 + t)}, 1);
      apb(1'b0, dlip_pkg::ADDR_ACC, 32'h0);
      `CHK("load_acc_var_shift_op", ld(i_dlip_ext_model.mem[40 + t], 1'b1, t), q)
    end
    for (int a = 0; a < 8; a++) begin
      exec({dlip_pkg::OPC_LAR_HI, 3'(a), 8'(60 + a)}, 1);
      apb(1'b0, 8'(dlip_pkg::ADDR_AUX0 + 4 * a), 32'h0);
      `CHK("lar", {16'h0, i_dlip_ext_model.mem[60 + a]}, q)
    end
    wait_cycles <= 4'h0;
    for (int p = 0; p < 16; p += 15) begin
      exec({dlip_pkg::OPC_IN_HI, 4'(p), 8'(100 + p)}, 1);
      apb(1'b0, dlip_pkg::ADDR_OPERAND, 32'h0);
      `CHK("in data", {16'h0, port_word(4'(p))}, q)
      `CHK("in store", port_word(4'(p)), i_dlip_ext_model.mem[100 + p])
      `CHK("in addr", {12'h000, 4'(p)}, port_seen)
    end
    // later variant: idle clears the mask and powers down
    apb(1'b1, dlip_pkg::ADDR_CTRL, 32'h0000_0007);
    exec(dlip_pkg::OPC_IDLE, 1);
    apb(1'b0, dlip_pkg::ADDR_TIMER, 32'h0);
    t0 = q;
    repeat (10) @(posedge pclk);
    apb(1'b0, dlip_pkg::ADDR_TIMER, 32'h0);
    `CHK("timer", 1'b1, q != t0)
    apb(1'b0, dlip_pkg::ADDR_STATUS, 32'h0);
    `CHK("idle pdown", 2'b11, q[1:0])
    apb(1'b0, dlip_pkg::ADDR_CTRL, 32'h0);
    `CHK("mask cleared", 1'b0, q[dlip_pkg::CTRL_INTERRUPT_MASK_FLAG])
    apb(1'b0, dlip_pkg::ADDR_PC, 32'h0);
    `CHK("pc hold", {16'h0, pc}, q)
    irq_maskable <= 1'b1;
    wait_wake();
    irq_maskable <= 1'b0;
    `CHK("masked wake", 1'b0, w)
    // earlier variant: mask kept, maskable request ignored
    apb(1'b0, dlip_pkg::ADDR_PC, 32'h0);
    pc = q[15:0];
    apb(1'b1, dlip_pkg::ADDR_CTRL, 32'h0000_0006);
    exec(dlip_pkg::OPC_IDLE, 1);
    irq_maskable <= 1'b1;
    repeat (8) @(posedge pclk);
    irq_maskable <= 1'b0;
    apb(1'b0, dlip_pkg::ADDR_STATUS, 32'h0);
    `CHK("still idle", 2'b01, q[1:0])
    apb(1'b0, dlip_pkg::ADDR_CTRL, 32'h0);
    `CHK("mask kept", 1'b1, q[dlip_pkg::CTRL_INTERRUPT_MASK_FLAG])
    irq_nonmaskable <= 1'b1;
    wait_wake();
    irq_nonmaskable <= 1'b0;
    `CHK("nmi wake", 1'b0, w)
    complete_run();
  end
endmodule
